/* File: hw/hpp_byte_hold.sv */
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// one byte-wide holding register
// ----------------------------------------
module hpp_byte_hold #(
	parameter int WIDTH = 8
) (
	input  wire logic             hclk,     // system clock
	input  wire logic             hresetn,  // async reset, low active
	input  wire logic             load,     // capture enable
	input  wire logic [WIDTH-1:0] din,      // value to hold
	output logic      [WIDTH-1:0] dout      // held value
);

	// loads only on request, otherwise keeps the byte
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dout <= '0;
		end else if (load) begin
			dout <= din;
		end
	end

endmodule : hpp_byte_hold

`default_nettype wire

/* File: hw/hpp_consts.svh */
`ifndef HPP_CONSTS_SVH
`define HPP_CONSTS_SVH

// ----------------------------------------
// timing figures and derived cycle counts
// ----------------------------------------
`define HPP_CLK_PERIOD_PS    10000
`define HPP_REF16_PERIOD_PS  62500
`define HPP_RAM_RD_DONE_PS   437500
`define HPP_REG_DONE_PS      187500
`define HPP_RAM_RD_EDGES     (`HPP_RAM_RD_DONE_PS / `HPP_REF16_PERIOD_PS)
`define HPP_REG_EDGES        (`HPP_REG_DONE_PS / `HPP_REF16_PERIOD_PS)
`define HPP_UNCONT_MAX_PS    107500
`define HPP_UNCONT_MAX_CYC   (`HPP_UNCONT_MAX_PS / `HPP_CLK_PERIOD_PS)
`define HPP_CONT_MAX_PS      5240000
`define HPP_CONT_MAX_CYC     (`HPP_CONT_MAX_PS / `HPP_CLK_PERIOD_PS)

// ----------------------------------------
// register offsets, fields, reset values
// ----------------------------------------
`define HPP_OFS_CTRL         8'h00
`define HPP_OFS_STATUS       8'h04
`define HPP_OFS_TEST_WORD    8'h08
`define HPP_OFS_TEST_CTRL    8'h0C
`define HPP_OFS_LAST_ADDR    8'h10
`define HPP_OFS_CYC_COUNT    8'h14
`define HPP_CTRL_TEST_BIT    0
`define HPP_CTRL_MON_BIT     1
`define HPP_CTRL_RST         2'h0
`define HPP_TEST_RST         16'h0000

`endif

/* File: hw/hpp_host_port.sv */
`timescale 1ns/10ps
`default_nettype none
`include "hpp_consts.svh"

module hpp_host_port (
	input  wire logic                     hclk,          // system clock
	input  wire logic                     hresetn,       // async reset, low active
	input  wire logic                     hsel,          // ahb slave select
	input  wire logic [7:0]               haddr,         // ahb byte address
	input  wire logic [1:0]               htrans,        // ahb transfer type
	input  wire logic                     hwrite,        // ahb write
	input  wire logic [2:0]               hsize,         // ahb size, word only
	input  wire logic [31:0]              hwdata,        // ahb write data
	input  wire logic                     hready,        // ahb bus ready
	output logic                          hreadyout,     // ahb slave ready
	output logic [31:0]                   hrdata,        // ahb read data
	output logic                          hresp,         // ahb response, okay
	input  wire hpp_pkg::hpp_host_in_type host_in,       // host pins
	input  wire hpp_pkg::hpp_strap_type   straps,        // strap inputs
	output logic                          host_access_active_n, // cycle active, low
	output logic                          host_transfer_done_n, // done, low
	output logic [15:0]                   host_data_out, // data bus drive value
	output logic                          host_data_oe_n,// low while driving data
	input  wire logic                     int_busy,      // protocol logic owns ram
	input  wire logic [15:0]              int_rdata,     // internal read data
	output hpp_pkg::hpp_mem_req_type      mem_req,       // internal request
	output logic                          emu_enable,    // emulated bus active
	output logic                          mon_enable,    // word monitor enable
	output logic [15:0]                   emu_word,      // emulated bus word
	output logic [15:0]                   emu_ctrl       // emulated bus control
);

	localparam int CONT_BOUND = `HPP_CONT_MAX_CYC;
	localparam int UNC_BOUND  = `HPP_UNCONT_MAX_CYC;

	// ----------------------------------------
	// state
	// ----------------------------------------
	hpp_pkg::hpp_state_type state_reg;
	logic [2:0]             cnt_reg;
	logic [2:0]             target_reg;
	logic [9:0]             wait_reg;
	logic                   cyc_read_reg;
	logic                   cyc_launch_reg;
	logic                   cyc_msb_reg;
	logic [15:0]            addr_hold_reg;
	logic                   sel_hold_reg;
	logic                   memreg_hold_reg;
	logic [15:0]            last_addr_reg;
	logic [15:0]            cyc_count_reg;
	logic [1:0]             ctrl_reg;
	logic                   ph_valid_reg;
	logic                   ph_write_reg;
	logic [7:0]             ph_addr_reg;
	logic [7:0]             msb_hold;
	logic [7:0]             lsb_hold;

	// ----------------------------------------
	// input decode
	// ----------------------------------------
	// latches modelled as gated pass-through over a held copy
	wire        gate_open = straps.transparent | host_in.addr_gate;
	wire [15:0] addr_eff  = gate_open ? host_in.addr : addr_hold_reg;
	wire        sel_eff_n = gate_open ? host_in.sel_n : sel_hold_reg;
	wire        mem_eff   = gate_open ? host_in.mem_reg : memreg_hold_reg;
	wire        is_read   = straps.polarity ? host_in.rd_wr : ~host_in.rd_wr;
	wire        lane_raw  = straps.polarity ? ~host_in.byte_half : host_in.byte_half;
	wire        lane_msb  = ~straps.width16 & lane_raw;
	// handshake: direction picks byte; zero wait: one byte for both
	wire        trig_msb  = straps.zero_wait ?
	                        (is_read ? straps.trigger : ~straps.trigger) :
	                        ~straps.trigger;
	wire        launch    = straps.width16 | (lane_msb == trig_msb);
	wire        forced    = (wait_reg == 10'(CONT_BOUND - 1));
	wire        want      = ~sel_eff_n & ~host_in.strobe_n;
	wire        start     = (state_reg == hpp_pkg::HPP_IDLE) & want &
	                        (~int_busy | forced);
	wire        last_edge = (state_reg == hpp_pkg::HPP_ACTIVE) &
	                        (cnt_reg == target_reg - 3'd1);
	wire [2:0]  target_nx = (is_read & mem_eff & launch) ?
	                        3'(`HPP_RAM_RD_EDGES) : 3'(`HPP_REG_EDGES);
	// 8-bit write pairs the host byte with the held byte
	wire [15:0] wdata_nx  = straps.width16 ? host_in.data :
	                        (lane_msb ? {host_in.data[7:0], lsb_hold} :
	                                    {msb_hold, host_in.data[7:0]});
	wire [7:0]  held_byte = cyc_msb_reg ? msb_hold : lsb_hold;
	wire [7:0]  int_byte  = cyc_msb_reg ? int_rdata[15:8] : int_rdata[7:0];
	wire [15:0] rd_nx     = straps.width16 ? int_rdata :
	                        (cyc_launch_reg ? {int_byte, int_byte} :
	                                          {held_byte, held_byte});
	wire        ld_hold   = last_edge & cyc_read_reg & cyc_launch_reg & ~straps.width16;
	wire        wr_byte   = start & ~is_read & ~launch;
	wire        ld_msb    = ld_hold | (wr_byte & lane_msb);
	wire        ld_lsb    = ld_hold | (wr_byte & ~lane_msb);
	wire [7:0]  msb_din   = ld_hold ? int_rdata[15:8] : host_in.data[7:0];
	wire [7:0]  lsb_din   = ld_hold ? int_rdata[7:0] : host_in.data[7:0];

	// ----------------------------------------
	// byte holding pair
	// ----------------------------------------
	hpp_byte_hold #(.WIDTH(8)) u_msb_hold (
		.hclk    (hclk),
		.hresetn (hresetn),
		.load    (ld_msb),
		.din     (msb_din),
		.dout    (msb_hold)
	);

	hpp_byte_hold #(.WIDTH(8)) u_lsb_hold (
		.hclk    (hclk),
		.hresetn (hresetn),
		.load    (ld_lsb),
		.din     (lsb_din),
		.dout    (lsb_hold)
	);

	// ----------------------------------------
	// address, select and mem/reg hold copies
	// ----------------------------------------
	// copy refreshes while open, so closing keeps the last value
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_hold_reg   <= 16'h0000;
			sel_hold_reg    <= 1'b1;
			memreg_hold_reg <= 1'b0;
		end else if (gate_open) begin
			addr_hold_reg   <= host_in.addr;
			sel_hold_reg    <= host_in.sel_n;
			memreg_hold_reg <= host_in.mem_reg;
		end
	end

	// ----------------------------------------
	// contention wait counter
	// ----------------------------------------
	// protocol logic is made to yield once the wait bound runs out
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wait_reg <= 10'h000;
		end else if (start || !want || state_reg != hpp_pkg::HPP_IDLE) begin
			wait_reg <= 10'h000;
		end else begin
			wait_reg <= wait_reg + 10'h001;
		end
	end

	// ----------------------------------------
	// cycle sequencer
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg            <= hpp_pkg::HPP_IDLE;
			cnt_reg              <= 3'h0;
			target_reg           <= 3'h3;
			cyc_read_reg         <= 1'b0;
			cyc_launch_reg       <= 1'b0;
			cyc_msb_reg          <= 1'b0;
			host_access_active_n <= 1'b1;
			host_transfer_done_n <= 1'b1;
		end else begin
			case (state_reg)
				hpp_pkg::HPP_IDLE: begin
					if (start) begin
						state_reg            <= hpp_pkg::HPP_ACTIVE;
						host_access_active_n <= 1'b0;
						cnt_reg              <= 3'h0;
						target_reg           <= target_nx;
						cyc_read_reg         <= is_read;
						cyc_launch_reg       <= launch;
						cyc_msb_reg          <= lane_msb;
					end
				end
				hpp_pkg::HPP_ACTIVE: begin
					cnt_reg <= cnt_reg + 3'h1;
					if (last_edge) begin
						// early strobe rise in zero wait: finish quietly
						if (host_in.strobe_n) begin
							state_reg            <= hpp_pkg::HPP_IDLE;
							host_access_active_n <= 1'b1;
						end else begin
							state_reg            <= hpp_pkg::HPP_DONE;
							host_transfer_done_n <= ~straps.zero_wait;
						end
					end
				end
				hpp_pkg::HPP_DONE: begin
					if (host_in.strobe_n) begin
						state_reg            <= hpp_pkg::HPP_IDLE;
						host_access_active_n <= 1'b1;
						host_transfer_done_n <= 1'b1;
					end
				end
				default: begin
					state_reg            <= hpp_pkg::HPP_IDLE;
					host_access_active_n <= 1'b1;
					host_transfer_done_n <= 1'b1;
				end
			endcase
		end
	end

	// ----------------------------------------
	// data bus drive
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			host_data_out  <= 16'h0000;
			host_data_oe_n <= 1'b1;
		end else if (last_edge && cyc_read_reg && !host_in.strobe_n) begin
			host_data_out  <= rd_nx;
			host_data_oe_n <= 1'b0;
		end else if (host_in.strobe_n) begin
			host_data_oe_n <= 1'b1;
		end
	end

	// ----------------------------------------
	// internal request, one pulse per launched cycle
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mem_req       <= '0;
			last_addr_reg <= 16'h0000;
			cyc_count_reg <= 16'h0000;
		end else begin
			mem_req.req <= start & launch;
			if (start) begin
				mem_req.write  <= ~is_read;
				mem_req.is_mem <= mem_eff;
				mem_req.addr   <= addr_eff;
				mem_req.wdata  <= wdata_nx;
				last_addr_reg  <= addr_eff;
				cyc_count_reg  <= cyc_count_reg + 16'h0001;
			end
		end
	end

	// ----------------------------------------
	// ahb-lite slave, one wait state per transfer
	// ----------------------------------------
	// the wait state lets hrdata come straight from a flop
	wire        ahb_take = hsel & htrans[1] & hready;
	wire        ahb_exec = ph_valid_reg & ~hreadyout;
	wire        ahb_wr   = ahb_exec & ph_write_reg;
	wire [31:0] rd_mux   =
		(ph_addr_reg == `HPP_OFS_CTRL)      ? {30'h0, ctrl_reg} :
		(ph_addr_reg == `HPP_OFS_STATUS)    ? {26'h0, straps.width16, straps.zero_wait,
		                                       int_busy, host_access_active_n, state_reg} :
		(ph_addr_reg == `HPP_OFS_TEST_WORD) ? {16'h0, emu_word} :
		(ph_addr_reg == `HPP_OFS_TEST_CTRL) ? {16'h0, emu_ctrl} :
		(ph_addr_reg == `HPP_OFS_LAST_ADDR) ? {16'h0, last_addr_reg} :
		(ph_addr_reg == `HPP_OFS_CYC_COUNT) ? {16'h0, cyc_count_reg} : 32'h0000_0000;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_valid_reg <= 1'b0;
			ph_write_reg <= 1'b0;
			ph_addr_reg  <= 8'h00;
			hreadyout    <= 1'b1;
			hrdata       <= 32'h0000_0000;
			hresp        <= 1'b0;
		end else if (ahb_exec) begin
			ph_valid_reg <= 1'b0;
			hreadyout    <= 1'b1;
			hrdata       <= ph_write_reg ? 32'h0000_0000 : rd_mux;
		end else if (ahb_take) begin
			ph_valid_reg <= 1'b1;
			ph_write_reg <= hwrite;
			ph_addr_reg  <= {haddr[7:2], 2'b00};
			hreadyout    <= 1'b0;
		end
	end

	// ----------------------------------------
	// test mode and emulation registers
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_reg <= `HPP_CTRL_RST;
			emu_word <= `HPP_TEST_RST;
			emu_ctrl <= `HPP_TEST_RST;
		end else if (ahb_wr) begin
			if (ph_addr_reg == `HPP_OFS_CTRL)      ctrl_reg <= hwdata[1:0];
			if (ph_addr_reg == `HPP_OFS_TEST_WORD) emu_word <= hwdata[15:0];
			if (ph_addr_reg == `HPP_OFS_TEST_CTRL) emu_ctrl <= hwdata[15:0];
		end
	end

	// both enables independent so monitor sees emulated traffic
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			emu_enable <= 1'b0;
			mon_enable <= 1'b0;
		end else begin
			emu_enable <= ctrl_reg[`HPP_CTRL_TEST_BIT];
			mon_enable <= ctrl_reg[`HPP_CTRL_MON_BIT];
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_req;
		(state_reg == hpp_pkg::HPP_IDLE) && want && !int_busy;
	endsequence

	sequence s_fall;
		$fell(host_access_active_n);
	endsequence

	start_uncont_a: assert property (@(posedge hclk) disable iff (!hresetn)
		s_req |-> ##[1:UNC_BOUND] !host_access_active_n)
		else $error("uncontended access did not start in time");

	start_cont_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(state_reg == hpp_pkg::HPP_IDLE) && want && !$past(want)
		|-> ##[1:CONT_BOUND] (!host_access_active_n || !want))
		else $error("contended access waited too long");

	done_third_a: assert property (@(posedge hclk) disable iff (!hresetn)
		s_fall ##0 (target_reg == 3'd3) ##3 !host_in.strobe_n[*1]
		|-> !host_transfer_done_n || !straps.zero_wait)
		else $error("done not on third edge");

	done_seventh_a: assert property (@(posedge hclk) disable iff (!hresetn)
		s_fall ##0 (target_reg == 3'd7) |-> host_transfer_done_n[*6])
		else $error("ram read done too early");

	done_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!host_transfer_done_n && !host_in.strobe_n
		|=> !host_transfer_done_n && !host_access_active_n)
		else $error("done dropped while strobe low");

	strobe_end_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(state_reg == hpp_pkg::HPP_DONE) && host_in.strobe_n
		|=> host_transfer_done_n && host_access_active_n && host_data_oe_n)
		else $error("strobe rise did not end cycle");

	no_launch_a: assert property (@(posedge hclk) disable iff (!hresetn)
		start && !straps.width16 && (lane_msb != trig_msb) |=> !mem_req.req)
		else $error("non-trigger byte started internal cycle");

	latch_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!straps.transparent && !host_in.addr_gate && $stable(straps.transparent)
		&& !$past(host_in.addr_gate) |-> addr_eff == $past(addr_eff))
		else $error("closed address latch moved");

	sense_a: assert property (@(posedge hclk) disable iff (!hresetn)
		start |=> mem_req.write == (straps.polarity ? ~$past(host_in.rd_wr)
		                                            : $past(host_in.rd_wr)))
		else $error("read/write sense wrong");

	test_mode_a: assert property (@(posedge hclk) disable iff (!hresetn)
		ctrl_reg == 2'b11 |=> emu_enable && mon_enable)
		else $error("test and monitor not both enabled");

endmodule : hpp_host_port

`default_nettype wire

/* File: hw/hpp_pkg.sv */
`default_nettype none

package hpp_pkg;

	// ----------------------------------------
	// host port sequencing
	// ----------------------------------------
	typedef enum logic [1:0] {
		HPP_IDLE   = 2'b00,
		HPP_ACTIVE = 2'b01,
		HPP_DONE   = 2'b10
	} hpp_state_type;

	// host pins sampled on hclk
	typedef struct packed {
		logic        sel_n;        // chip select, low active
		logic        strobe_n;     // host_strobe, low active
		logic        rd_wr;        // direction, sense set by polarity strap
		logic        mem_reg;      // 1 memory, 0 register
		logic        byte_half;    // byte lane select, 8-bit mode only
		logic        addr_gate;    // address_hold_gate
		logic [15:0] addr;         // address inputs
		logic [15:0] data;         // data bus input
	} hpp_host_in_type;

	// configuration straps
	typedef struct packed {
		logic polarity;            // sense polarity strap
		logic zero_wait;           // 1 handshake, 0 zero wait
		logic trigger;             // trigger strap
		logic width16;             // 1 16-bit, 0 8-bit
		logic transparent;         // 1 transparent, 0 buffered
	} hpp_strap_type;

	// request towards the internal memory and register bus
	typedef struct packed {
		logic        req;
		logic        write;
		logic        is_mem;
		logic [15:0] addr;
		logic [15:0] wdata;
	} hpp_mem_req_type;

endpackage : hpp_pkg

`default_nettype wire

/* File: tb/hpp_host_model.sv */
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// host processor on the parallel port
// ----------------------------------------
module hpp_host_model (
	input  wire logic                     hclk,   // system clock
	input  wire logic                     hs,     // handshake strap
	input  wire logic                     pol,    // polarity strap
	input  wire logic                     act_n,  // cycle active, low
	input  wire logic                     done_n, // transfer done, low
	input  wire logic [15:0]              din,    // device data drive
	input  wire logic                     oe_n,   // device drives, low
	output var  hpp_pkg::hpp_host_in_type pins    // host pins
);
	logic busy;
	int   wait_n;

	// released bus flips each cycle so stale data never looks valid
	initial begin
		busy = 1'b0;
		pins = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 16'h0000, 16'hA5A5};
	end
	always @(posedge hclk) begin
		if (!busy) begin
			pins.data <= ~pins.data;
		end
	end

	// open the address gate for one edge
	task automatic preset(input logic [15:0] a);
		@(posedge hclk);
		pins.addr      <= a;
		pins.sel_n     <= 1'b0; // select is latched with the address
		pins.addr_gate <= 1'b1;
	endtask : preset

	// one strobe cycle, strobe held as long as the caller asks
	task automatic cycle(input logic rw, mem, half, gate, input logic [15:0] a, wd,
		input int hold, output logic [15:0] rd, output int edges, output logic ok);
		int   n;
		logic rd_cyc;
		n = 0;
		ok = 1'b1;
		rd_cyc = pol ? rw : ~rw;
		busy = 1'b1;
		@(posedge hclk);
		pins <= '{1'b0, 1'b0, rw, mem, half, gate, a, wd};
		while (act_n !== 1'b0 && n < 600) begin
			@(negedge hclk);
			n++;
		end
		wait_n = n;
		edges = (act_n === 1'b0) ? -2 : -1;
		n = 0;
		// done is only an acknowledge with handshake straps
		while (hs && done_n !== 1'b0 && n < 20) begin
			@(negedge hclk);
			n++;
		end
		if (edges == -2 && done_n === 1'b0) edges = n;
		rd = din;
		// host may stall after done, device must keep both asserted
		repeat (hold) begin
			@(negedge hclk);
			// data is driven on reads only
			if (edges > 0 && (done_n | act_n | (oe_n == rd_cyc)) !== 1'b0) ok = 1'b0;
		end
		@(posedge hclk);
		pins.strobe_n <= 1'b1;
		pins.sel_n    <= 1'b1;
		n = 0;
		// zero-wait host leaves early, the device finishes on its own
		do begin
			@(negedge hclk);
			n++;
		end while ((act_n & done_n & oe_n) !== 1'b1 && n < (hs ? 3 : 12));
		if ((act_n & done_n & oe_n) !== 1'b1) ok = 1'b0;
		busy = 1'b0;
	endtask : cycle
endmodule : hpp_host_model
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
`include "hpp_consts.svh"

module testbench;
	logic                     hclk;
	logic                     hresetn;
	logic                     hsel;
	logic [7:0]               haddr;
	logic [1:0]               htrans;
	logic                     hwrite;
	logic [31:0]              hwdata;
	logic                     hreadyout;
	logic [31:0]              hrdata;
	logic                     hresp;
	hpp_pkg::hpp_host_in_type pins;
	hpp_pkg::hpp_strap_type   straps;
	hpp_pkg::hpp_mem_req_type mem_req;
	hpp_pkg::hpp_mem_req_type last_req;
	logic                     act_n;
	logic                     done_n;
	logic [15:0]              dout;
	logic                     oe_n;
	logic                     int_busy;
	logic [15:0]              int_rdata;
	logic                     emu_en;
	logic                     mon_en;
	logic [15:0]              emu_word;
	logic [31:0]              rd;
	logic [15:0]              got;
	logic                     ok;
	int                       edges;
	int                       n_req;
	int                       req0;
	int                       n_fail;
	int                       checked;

	hpp_host_port uut (
		.hclk                 (hclk),
		.hresetn              (hresetn),
		.hsel                 (hsel),
		.haddr                (haddr),
		.htrans               (htrans),
		.hwrite               (hwrite),
		.hsize                (3'h2),
		.hwdata               (hwdata),
		.hready               (hreadyout),
		.hreadyout            (hreadyout),
		.hrdata               (hrdata),
		.hresp                (hresp),
		.host_in              (pins),
		.straps               (straps),
		.host_access_active_n (act_n),
		.host_transfer_done_n (done_n),
		.host_data_out        (dout),
		.host_data_oe_n       (oe_n),
		.int_busy             (int_busy),
		.int_rdata            (int_rdata),
		.mem_req              (mem_req),
		.emu_enable           (emu_en),
		.mon_enable           (mon_en),
		.emu_word             (emu_word),
		.emu_ctrl             ()
	);

	hpp_host_model host (
		.hclk   (hclk),
		.hs     (straps.zero_wait),
		.pol    (straps.polarity),
		.act_n  (act_n),
		.done_n (done_n),
		.din    (dout),
		.oe_n   (oe_n),
		.pins   (pins)
	);

	// ----------------------------------------
	// clock, request monitor, helpers
	// ----------------------------------------
	always #5 hclk = ~hclk;

	always @(posedge hclk) begin
		if (mem_req.req === 1'b1) begin
			n_req++;
			last_req = mem_req;
		end
	end

	task automatic chk(input string what, input logic [31:0] exp, got_v);
		checked++;
		if (got_v !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, got_v);
		end
	endtask : chk

	task automatic finish_test;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : finish_test

	// single word transfer; waits on hready, never on a fixed count
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge hclk);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= a;
		hwrite <= wr;
		@(posedge hclk);
		while (hreadyout !== 1'b1 && n < 50) begin
			@(posedge hclk);
			n++;
		end
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		rd = hrdata;
		if (n >= 50) begin
			n_fail++;
			finish_test();
		end
	endtask : ahb

	task automatic hc(input logic rw, mem, half, gate, input logic [15:0] a, wd, input int hold);
		req0 = n_req;
		host.cycle(rw, mem, half, gate, a, wd, hold, got, edges, ok);
		if (edges == -1) begin
			n_fail++;
			finish_test();
		end else begin
			chk("strobe handshake", 1, ok);
		end
	endtask : hc

	initial begin
		repeat (100000) @(posedge hclk);
		n_fail++;
		finish_test();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		{hsel, haddr, htrans, hwrite, hwdata} = '0;
		straps = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
		int_busy = 1'b0;
		int_rdata = 16'hBEEF;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		ahb(1'b0, `HPP_OFS_CTRL, 32'h0);
		chk("ctrl reset", 32'h0, rd);
		ahb(1'b1, `HPP_OFS_CTRL, 32'h3);
		ahb(1'b1, `HPP_OFS_TEST_WORD, 32'h1234);
		chk("test and monitor", 2'h3, {emu_en, mon_en});
		chk("test word", 16'h1234, emu_word);
		ahb(1'b0, `HPP_OFS_TEST_WORD, 32'h0);
		chk("test word read", 32'h1234, rd);
		ahb(1'b1, `HPP_OFS_TEST_CTRL, 32'h00C3);
		ahb(1'b0, `HPP_OFS_TEST_CTRL, 32'h0);
		chk("test ctrl read", 32'h00C3, rd);
		ahb(1'b0, 8'h40, 32'h0);
		chk("unmapped read", 32'h0, {rd[31:1], hresp});
		// 16-bit handshake: ram read, register read, write
		hc(1'b1, 1'b1, 1'b0, 1'b1, 16'h0123, 16'h0, 4);
		chk("uncontended start", 1, host.wait_n <= 10);
		chk("ram read done", 7, edges);
		chk("ram read data", 16'hBEEF, got);
		chk("read request", {1'b0, 1'b1, 16'h0123}, {last_req.write, last_req.is_mem, last_req.addr});
		hc(1'b1, 1'b0, 1'b0, 1'b1, 16'h0005, 16'h0, 0);
		chk("reg read done", 3, edges);
		hc(1'b0, 1'b1, 1'b0, 1'b1, 16'h0200, 16'h5AC3, 1);
		chk("write done", 3, edges);
		chk("write word", {1'b1, 16'h5AC3}, {last_req.write, last_req.wdata});
		// inverted sense, then address gate held closed
		straps.polarity <= 1'b0;
		hc(1'b0, 1'b1, 1'b0, 1'b1, 16'h0300, 16'h0, 0);
		chk("inverted read", {1'b0, 8'h7}, {last_req.write, edges[7:0]});
		host.preset(16'h0777);
		hc(1'b1, 1'b0, 1'b0, 1'b0, 16'h0999, 16'h1, 0);
		chk("held address", 16'h0777, last_req.addr);
		straps.transparent <= 1'b1;
		host.preset(16'h0777);
		hc(1'b1, 1'b0, 1'b0, 1'b0, 16'h0999, 16'h1, 0);
		chk("transparent address", 16'h0999, last_req.addr);
		// 8-bit pairing through the byte holds
		straps <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
		int_rdata <= 16'hABCD;
		hc(1'b0, 1'b1, 1'b0, 1'b1, 16'h0040, 16'h0012, 0);
		chk("msb write held", 0, n_req - req0);
		hc(1'b0, 1'b1, 1'b1, 1'b1, 16'h0040, 16'h0034, 0);
		chk("byte pair write", {8'h1, 16'h1234}, {n_req[7:0] - req0[7:0], last_req.wdata});
		hc(1'b1, 1'b1, 1'b0, 1'b1, 16'h0040, 16'h0, 0);
		chk("msb read", {8'h7, 16'hABAB}, {edges[7:0], got});
		hc(1'b1, 1'b1, 1'b1, 1'b1, 16'h0040, 16'h0, 0);
		chk("lsb held read", {8'h0, 16'hCDCD}, {n_req[7:0] - req0[7:0], got});
		straps.polarity <= 1'b0;
		hc(1'b0, 1'b1, 1'b1, 1'b1, 16'h0040, 16'h0, 0);
		chk("swapped lane", 1, n_req - req0);
		// every trigger strap and wait mode, both directions, both lanes
		for (int i = 0; i < 16; i++) begin
			straps <= {1'b1, i[3], i[2], 1'b0, 1'b0};
			hc(i[1], 1'b1, i[0], 1'b1, 16'h0050, 16'h0066, 0);
			chk("trigger byte", (!i[0]) == (i[3] ? i[1] == i[2] : !i[2]), n_req - req0);
		end
		straps <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
		hc(1'b1, 1'b1, 1'b1, 1'b1, 16'h0060, 16'h0, 0);
		chk("lane ignored", {8'h1, 16'hABCD}, {n_req[7:0] - req0[7:0], got});
		// protocol logic keeps the ram for the whole wait
		int_busy <= 1'b1;
		hc(1'b1, 1'b0, 1'b0, 1'b1, 16'h0001, 16'h0, 0);
		chk("contended start", 1, host.wait_n >= 500 && host.wait_n <= 526);
		int_busy <= 1'b0;
		ahb(1'b0, `HPP_OFS_LAST_ADDR, 32'h0);
		chk("last address", 32'h0001, rd);
		finish_test();
	end
endmodule : testbench
`default_nettype wire
